// *** design/llt_params.svh ***
/*
 * Constants of the light level threshold block: register offsets, field
 * positions, reset values and the scaling between settings and the current
 * scale of the measured input.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef LLT_PARAMS_SVH
`define LLT_PARAMS_SVH

// register offsets
`define LLT_SENSOR1_CONFIG           8'h31
`define LLT_SENSOR2_CONFIG           8'h32
`define LLT_SENSOR1_OFFICE_TRIP      8'h33
`define LLT_SENSOR1_OFFICE_HYSTERESIS 8'h34
`define LLT_SENSOR1_DARK_TRIP        8'h35
`define LLT_SENSOR1_DARK_HYSTERESIS  8'h36
`define LLT_SENSOR2_OFFICE_TRIP      8'h37
`define LLT_SENSOR2_OFFICE_HYSTERESIS 8'h38
`define LLT_SENSOR2_DARK_TRIP        8'h39
`define LLT_SENSOR2_DARK_HYSTERESIS  8'h3A

// map window and index layout
`define LLT_REG_BASE                 8'h31
`define LLT_REG_COUNT                10
`define LLT_IDX_CONFIG               0
`define LLT_IDX_OFFICE_TRIP          2
`define LLT_IDX_OFFICE_HYS           3
`define LLT_IDX_DARK_TRIP            4
`define LLT_IDX_DARK_HYS             5
`define LLT_IDX_SENSOR_STRIDE        4

// configuration fields
`define LLT_OFFICE_EN_BIT            0
`define LLT_DARK_EN_BIT              1
`define LLT_CONFIG_MASK              8'h03

// reset values
`define LLT_REG_RESET                8'h00
`define LLT_RDATA_RESET              8'h00

// measured input: 13-bit code, 0.125 uA per step
`define LLT_ADC_W                    13
`define LLT_CMP_W                    14
// office step 4 uA = 32 input steps, dark step 0.5 uA = 4 input steps
`define LLT_OFFICE_SHIFT             5
`define LLT_DARK_SHIFT               2

`endif

// *** design/llt_pkg.sv ***
/*
 * Types of the light level threshold block.
 * Assumes llt_params.svh for the widths used here.
 */
`include "llt_params.svh"

package llt_pkg;

  typedef struct packed {
    logic office_level_flag;
    logic dark_level_flag;
  } llt_cmp_state_t;

  typedef struct packed {
    logic [`LLT_REG_COUNT-1:0][7:0] regs;
    logic [7:0]                     rdata;
    logic                           rvalid;
  } llt_top_state_t;

endpackage

// *** design/llt_level_cmp.sv ***
/*
 * One sensor's level classifier: office and dark flags with hysteresis.
 * Assumes a synchronous reset copy and a measured input with a one-cycle
 * valid strobe, both on ref_clk.
 */
`timescale 1ns/100ps
`include "llt_params.svh"

module llt_level_cmp
  import llt_pkg::*;
#(
  parameter int ADC_W = `LLT_ADC_W,
  parameter int CMP_W = `LLT_CMP_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             sample_valid,
  input  wire logic [ADC_W-1:0] sample,
  input  wire logic             office_enable,
  input  wire logic             dark_compare_enable,
  input  wire logic [7:0]       office_trip_threshold,
  input  wire logic [7:0]       office_hysteresis_value,
  input  wire logic [7:0]       dark_trip_threshold,
  input  wire logic [7:0]       dark_hysteresis_value,
  output logic                  office_level_flag,
  output logic                  dark_level_flag
);

  llt_cmp_state_t   st;
  llt_cmp_state_t   next_st;
  logic [CMP_W-1:0] level;
  logic [CMP_W-1:0] office_set;
  logic [CMP_W-1:0] office_rel;
  logic [CMP_W-1:0] dark_set;
  logic [CMP_W-1:0] dark_rel;
  logic [8:0]       office_sum;
  logic [8:0]       dark_sum;

  assign office_sum = {1'b0, office_trip_threshold} + {1'b0, office_hysteresis_value};
  assign dark_sum   = {1'b0, dark_trip_threshold} + {1'b0, dark_hysteresis_value};

  // office codes at 4 uA steps
  assign office_set = CMP_W'(office_trip_threshold) << `LLT_OFFICE_SHIFT;
  assign office_rel = CMP_W'(office_sum) << `LLT_OFFICE_SHIFT;
  // dark codes at 0.5 uA steps
  assign dark_set   = CMP_W'(dark_trip_threshold) << `LLT_DARK_SHIFT;
  assign dark_rel   = CMP_W'(dark_sum) << `LLT_DARK_SHIFT;
  assign level      = CMP_W'(sample);

  always_comb begin
    next_st = st;
    if (sample_valid) begin
      if (!office_enable) begin
        next_st.office_level_flag = 1'b0;
      end else if (level < office_set) begin
        next_st.office_level_flag = 1'b1;
      end else if (level > office_rel) begin
        next_st.office_level_flag = 1'b0;
      end
      if (!dark_compare_enable) begin
        next_st.dark_level_flag = 1'b0;
      end else if (level < dark_set) begin
        next_st.dark_level_flag = 1'b1;
      end else if (level > dark_rel) begin
        next_st.dark_level_flag = 1'b0;
      end
    end
  end

  // between the two thresholds the flag holds: that is the hysteresis
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign office_level_flag = st.office_level_flag;
  assign dark_level_flag   = st.dark_level_flag;

endmodule

// *** design/llt_top.sv ***
/*
 * Light level threshold block: register file of trip points, hysteresis
 * and enables for two light sensors, and two level classifiers.
 * Assumes a register port driven on ref_clk and measured inputs with valid
 * strobes from a conversion front end on the same clock.
 */
`timescale 1ns/100ps
`include "llt_params.svh"

// Functional notes
// - A sensor's office flag is set when its input falls below the office trip.
// - The office flag clears only when the input rises above office trip plus hysteresis, or on a sample while office enable is 0.
// - A sensor's dark flag is set when its input falls below the dark trip.
// - The dark flag clears only when the input rises above dark trip plus hysteresis, or on a sample while dark enable is 0.
// - Office trip and hysteresis are 8-bit codes of 4 uA per step, 0 to 1020 uA.
// - Dark trip and hysteresis are 8-bit codes of 0.5 uA per step, 0 to 127.5 uA.
// - Each sensor has its own four 8-bit threshold settings.
// - A sensor's dark comparison runs only while its dark enable bit is 1.
// - The first sensor has its own office trip register driving its office set.
module llt_top
  import llt_pkg::*;
#(
  parameter int ADC_W = `LLT_ADC_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic [ADC_W-1:0] sensor1_sample,
  input  wire logic             sensor1_sample_valid,
  input  wire logic [ADC_W-1:0] sensor2_sample,
  input  wire logic             sensor2_sample_valid,
  output logic                  sensor1_office_level_flag,
  output logic                  sensor1_dark_level_flag,
  output logic                  sensor2_office_level_flag,
  output logic                  sensor2_dark_level_flag
);

  localparam int NSENS = 2;

  logic [1:0]            rst_pipe;
  logic                  rst_n;
  llt_top_state_t        st;
  llt_top_state_t        next_st;
  logic                  addr_hit;
  logic [3:0]            addr_idx;
  logic [NSENS-1:0][ADC_W-1:0] samples;
  logic [NSENS-1:0]      sample_valids;
  logic [NSENS-1:0]      office_flags;
  logic [NSENS-1:0]      dark_flags;
  logic [`LLT_REG_COUNT-1:0]      wr_hit;
  logic [`LLT_REG_COUNT-1:0][7:0] wr_val;

  // asserted at once, released cleanly on the clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign addr_hit = (reg_addr >= `LLT_REG_BASE) &&
                    (reg_addr < (`LLT_REG_BASE + 8'(`LLT_REG_COUNT)));
  assign addr_idx = 4'(reg_addr - `LLT_REG_BASE);

  genvar e;
  generate
    for (e = 0; e < `LLT_REG_COUNT; e = e + 1) begin : g_entry
      assign wr_hit[e] = reg_wr && addr_hit && (addr_idx == 4'(e));
      if (e < NSENS) begin : g_cfg
        // only the enable bits are kept; the rest read as zero
        assign wr_val[e] = reg_wdata & `LLT_CONFIG_MASK;
      end else begin : g_byte
        assign wr_val[e] = reg_wdata;
      end
    end
  endgenerate

  always_comb begin
    next_st        = st;
    next_st.rvalid = reg_rd;
    if (reg_rd) begin
      // unmapped offsets read as zero
      next_st.rdata = addr_hit ? st.regs[addr_idx] : `LLT_RDATA_RESET;
    end
    for (int i = 0; i < `LLT_REG_COUNT; i++) begin
      if (wr_hit[i]) begin
        next_st.regs[i] = wr_val[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.regs   <= {`LLT_REG_COUNT{`LLT_REG_RESET}};
      st.rdata  <= `LLT_RDATA_RESET;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata  = st.rdata;
  assign reg_rvalid = st.rvalid;

  assign samples       = {sensor2_sample, sensor1_sample};
  assign sample_valids = {sensor2_sample_valid, sensor1_sample_valid};

  genvar s;
  generate
    for (s = 0; s < NSENS; s = s + 1) begin : g_sensor
      logic [1:0] cfg;
      logic [7:0] office_trip;
      logic [7:0] office_hys;
      logic [7:0] dark_trip;
      logic [7:0] dark_hys;

      // upper config bits always read zero, so only two are taken
      assign cfg         = st.regs[`LLT_IDX_CONFIG + s][1:0];
      // each sensor's office trip from its own register
      assign office_trip = st.regs[`LLT_IDX_OFFICE_TRIP + s * `LLT_IDX_SENSOR_STRIDE];
      assign office_hys  = st.regs[`LLT_IDX_OFFICE_HYS + s * `LLT_IDX_SENSOR_STRIDE];
      assign dark_trip   = st.regs[`LLT_IDX_DARK_TRIP + s * `LLT_IDX_SENSOR_STRIDE];
      assign dark_hys    = st.regs[`LLT_IDX_DARK_HYS + s * `LLT_IDX_SENSOR_STRIDE];

      llt_level_cmp #(
        .ADC_W (ADC_W),
        .CMP_W (`LLT_CMP_W)
      ) u_cmp (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n),
        .sample_valid            (sample_valids[s]),
        .sample                  (samples[s]),
        .office_enable           (cfg[`LLT_OFFICE_EN_BIT]),
        .dark_compare_enable     (cfg[`LLT_DARK_EN_BIT]),
        .office_trip_threshold   (office_trip),
        .office_hysteresis_value (office_hys),
        .dark_trip_threshold     (dark_trip),
        .dark_hysteresis_value   (dark_hys),
        .office_level_flag       (office_flags[s]),
        .dark_level_flag         (dark_flags[s])
      );
    end
  endgenerate

  assign sensor1_office_level_flag = office_flags[0];
  assign sensor1_dark_level_flag   = dark_flags[0];
  assign sensor2_office_level_flag = office_flags[1];
  assign sensor2_dark_level_flag   = dark_flags[1];

endmodule

// *** sim/llt_top_assertions.sv ***
/* checker: register port, sensor 1 level flag relations and a sensor 2 dark flag check
   assumes llt_top ports only; bound at the foot of this file */
`timescale 1ns/100ps
module llt_chk #(parameter int ADC_W = 13) (
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic             reg_rvalid,
  input wire logic [ADC_W-1:0] sensor1_sample,
  input wire logic             sensor1_sample_valid,
  input wire logic [ADC_W-1:0] sensor2_sample,
  input wire logic             sensor2_sample_valid,
  input wire logic             sensor1_office_level_flag,
  input wire logic             sensor1_dark_level_flag,
  input wire logic             sensor2_office_level_flag,
  input wire logic             sensor2_dark_level_flag
);
  // shadow of sensor 1 settings, seen from the write strobes
  logic [7:0] ot1;
  logic [7:0] dt1;
  logic [1:0] cf1;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ot1 <= 8'h00;
      dt1 <= 8'h00;
      cf1 <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h31) cf1 <= reg_wdata[1:0];
      if (reg_addr == 8'h33) ot1 <= reg_wdata;
      if (reg_addr == 8'h35) dt1 <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_ans; ##1 reg_rvalid; endsequence
  property p_rd; reg_rd |-> s_ans; endproperty
  property p_nord; !reg_rd |=> !reg_rvalid; endproperty
  property p_oset; sensor1_sample_valid && cf1[0] && sensor1_sample < {ot1, 5'h00}
    |=> sensor1_office_level_flag; endproperty
  property p_dset; sensor1_sample_valid && cf1[1] && sensor1_sample < {3'h0, dt1, 2'h0}
    |=> sensor1_dark_level_flag; endproperty
  property p_hold; !sensor1_sample_valid |=> $stable(sensor1_office_level_flag); endproperty
  property p_orel; $fell(sensor1_office_level_flag) |-> $past(sensor1_sample_valid);
  endproperty
  property p_doff; sensor1_sample_valid && !cf1[1] |=> !sensor1_dark_level_flag; endproperty
  property p_s2; $rose(sensor2_dark_level_flag) |-> $past(sensor2_sample_valid); endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_nord: assert property (p_nord) else $error("answer without read");
  a_oset: assert property (p_oset) else $error("office flag not set");
  a_dset: assert property (p_dset) else $error("dark flag not set");
  a_hold: assert property (p_hold) else $error("flag moved without sample");
  a_orel: assert property (p_orel) else $error("office flag fell without sample");
  a_doff: assert property (p_doff) else $error("dark flag set while disabled");
  a_s2: assert property (p_s2) else $error("sensor 2 dark flag rose alone");
endmodule
bind llt_top llt_chk #(.ADC_W(ADC_W)) i_chk (.*);

// *** sim/tb.sv ***
/* bench: llt_top against an integer flag model
   assumes the design package and modules compile first */
`timescale 1ns/100ps
module tb;
  logic        ref_clk, rstn, reg_wr, reg_rd, s1v, s2v;
  logic [7:0]  addr, wdata, rdata;
  logic        rvalid;
  logic [12:0] s1, s2;
  logic [3:0]  fl;
  logic        mf [4];
  int          rg [8'h31:8'h3A];
  int          err_total, n_compared;
  llt_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .sensor1_sample(s1), .sensor1_sample_valid(s1v), .sensor2_sample(s2),
    .sensor2_sample_valid(s2v), .sensor1_office_level_flag(fl[3]),
    .sensor1_dark_level_flag(fl[2]), .sensor2_office_level_flag(fl[1]),
    .sensor2_dark_level_flag(fl[0]));
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) begin
      reg_wr <= 1;
      addr <= a;
      wdata <= d;
    end
    @(posedge ref_clk) reg_wr <= 0;
    // config keeps two bits only
    if (a >= 8'h31 && a <= 8'h3A) rg[a] = (a < 8'h33) ? d & 3 : d;
  endtask
  task automatic rd(input logic [7:0] a);
    int e;
    e = (a >= 8'h31 && a <= 8'h3A) ? rg[a] : 0;
    @(posedge ref_clk) begin
      reg_rd <= 1;
      addr <= a;
    end
    @(posedge ref_clk) reg_rd <= 0;
    #1 chk(rvalid, 1'h1);
    chk(rdata, e[7:0]);
  endtask
  task automatic smp(input int a, input int b);
    int v[2];
    v = '{a, b};
    @(posedge ref_clk) begin
      {s1v, s2v, s1, s2} <= {2'h3, a[12:0], b[12:0]};
    end
    // garbage after the strobe must be ignored
    @(posedge ref_clk) {s1v, s2v, s1, s2} <= {2'h0, ~s1, ~s2};
    for (int i = 0; i < 4; i++) begin
      int k, j, t, h, sc;
      k = i / 2;
      j = i % 2;
      sc = j ? 4 : 32;
      t = rg[8'h33 + 4 * k + 2 * j];
      h = rg[8'h34 + 4 * k + 2 * j];
      if (!rg[8'h31 + k][j]) mf[i] = 0;
      else if (v[k] < t * sc) mf[i] = 1;
      else if (v[k] > (t + h) * sc) mf[i] = 0;
    end
    #1 chk(fl, {mf[0], mf[1], mf[2], mf[3]});
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, addr, wdata, s1, s2, s1v, s2v} = '0;
    err_total = 0;
    n_compared = 0;
    foreach (mf[i]) mf[i] = 0;
    foreach (rg[i]) rg[i] = 0;
    void'($urandom(71832));
    repeat (3) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    #1 chk(fl, 4'h0);
    for (int a = 8'h30; a < 8'h3C; a++) rd(8'(a));
    $display("test reset values done");
    for (int a = 8'h30; a < 8'h3C; a++) begin
      wr(8'(a), 8'($urandom));
      rd(8'(a));
    end
    $display("test register access done");
    // full scale trip plus hysteresis must never wrap
    wr(8'h31, 8'h03);
    wr(8'h33, 8'hFF);
    wr(8'h34, 8'hFF);
    smp(0, 0);
    smp(8191, 8191);
    $display("test release width done");
    for (int n = 0; n < 300; n++) begin
      if (n % 20 == 0) begin
        for (int a = 8'h31; a < 8'h3B; a++) wr(8'(a), 8'($urandom));
      end
      smp($urandom % (n[0] ? 8192 : 1100), $urandom % (n[1] ? 8192 : 1100));
    end
    $display("test random levels done");
    // reset mid-run: flags and settings fall back to zero
    @(posedge ref_clk) rstn <= 0;
    @(posedge ref_clk) #1 chk(fl, 4'h0);
    foreach (mf[i]) mf[i] = 0;
    foreach (rg[i]) rg[i] = 0;
    @(posedge ref_clk) rstn <= 1;
    repeat (3) @(posedge ref_clk);
    for (int a = 8'h31; a < 8'h3B; a++) rd(8'(a));
    wr(8'h37, 8'h01);
    wr(8'h32, 8'h01);
    smp(0, 0);
    $display("test mid-run reset done");
    complete_run();
  end
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule
